// ==== alu_status_flags.sv ====
`timescale 1ns/1ps

module alu_status_flags (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         exec_valid,
  input  asf_pkg::asf_exec_t exec_req,
  output logic [7:0]        exec_result,
  output logic [7:0]        flags_view,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic [2:0]   s_axi_awprot,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic [2:0]   s_axi_arprot,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp
);

  // ****************************************
  // datapath
  // ****************************************

  logic [7:0]          alu_result;
  asf_pkg::asf_flags_t calc;
  asf_pkg::asf_flags_t affect;
  logic [4:0]          flag_q;
  logic                sw_wr;
  logic [4:0]          sw_data;

  asf_alu_core u_alu (
    .req      (exec_req),
    .carry_in (flag_q[asf_pkg::CARRY_POS]),
    .result   (alu_result),
    .calc     (calc),
    .affect   (affect)
  );

  // ****************************************
  // register bus
  // ****************************************

  // prot is accepted but plays no part: one register, no privilege split
  asf_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .awaddr  (s_axi_awaddr),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .bresp   (s_axi_bresp),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .araddr  (s_axi_araddr),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .sw_wr   (sw_wr),
    .sw_data (sw_data),
    .rd_view (flags_view)
  );

  // ****************************************
  // flag register
  // ****************************************

  // upper three bits are not stored
  assign flags_view = {asf_pkg::UNIMPL_READ, flag_q};

  // no reset on the flags: they power up unknown, software must seed them
  // an instruction and a bus write in the same cycle: the instruction wins
  genvar gi;
  generate
    for (gi = 0; gi < asf_pkg::FLAG_W; gi++)
    begin : g_flag
      always_ff @(posedge aclk)
      begin
        // an affected flag takes the ALU value
        if (exec_valid && affect[gi])
          flag_q[gi] <= calc[gi];
        // plain destination write
        // an op that sets any flag blocks the data write on all five
        else if (exec_valid && exec_req.dest_flags && affect == 5'h00)
          flag_q[gi] <= alu_result[gi];
        else if (sw_wr && !exec_valid)
          flag_q[gi] <= sw_data[gi];
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      exec_result <= asf_pkg::RESULT_RESET;
    else if (exec_valid)
      exec_result <= alu_result;
  end

  // ****************************************
  // checking helpers
  // ****************************************

  logic       flags_loaded;
  logic [8:0] ref_add;
  logic [4:0] ref_nib;
  logic       ref_wrap;
  logic       ref_ge;
  logic       ref_nib_ge;
  logic [7:0] ref_a;
  logic       is_logic;
  logic       is_plain;
  logic [7:0] ref_diff;
  logic       ref_sub_wrap;
  logic [4:0] hold_mask;

  // flags are only trusted once a bus write or a plain destination write has loaded all five bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_loaded <= 1'b0;
    else if ((sw_wr && !exec_valid) || (exec_valid && exec_req.dest_flags && affect == 5'h00))
      flags_loaded <= 1'b1;
  end

  always_comb
  begin
    ref_a      = exec_req.a;
    ref_add    = {1'b0, exec_req.a} + {1'b0, exec_req.b};
    ref_nib    = {1'b0, exec_req.a[3:0]} + {1'b0, exec_req.b[3:0]};
    ref_wrap   = (exec_req.a[7] == exec_req.b[7]) && (ref_add[7] != exec_req.a[7]);
    ref_ge     = (exec_req.a >= exec_req.b);
    ref_nib_ge = (exec_req.a[3:0] >= exec_req.b[3:0]);
    ref_diff     = exec_req.a - exec_req.b;
    ref_sub_wrap = (exec_req.a[7] != exec_req.b[7]) && (ref_diff[7] != exec_req.a[7]);
    hold_mask    = ~affect;
    is_logic   = exec_req.op inside {asf_pkg::OP_ADD, asf_pkg::OP_SUB, asf_pkg::OP_AND,
                                     asf_pkg::OP_IOR, asf_pkg::OP_XOR};
    is_plain   = exec_req.op inside {asf_pkg::OP_MOV, asf_pkg::OP_BCLR, asf_pkg::OP_BSET,
                                     asf_pkg::OP_SWAP};
  end

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_op(asf_pkg::asf_op_t op);
    exec_valid && exec_req.op == op;
  endsequence

  sequence s_add;
    s_op(asf_pkg::OP_ADD);
  endsequence

  sequence s_sub;
    s_op(asf_pkg::OP_SUB);
  endsequence

  sequence s_to_flags;
    exec_valid && exec_req.dest_flags;
  endsequence

  sequence s_rotate;
    s_op(asf_pkg::OP_RLC) or s_op(asf_pkg::OP_RRC);
  endsequence

  a_dest_write_blocked: assert property (
    s_to_flags and s_add |=> flag_q == $past(calc))
    else $error("affected flags took destination data");

  a_negative_msb: assert property (
    (s_add or s_sub) |=> flag_q[asf_pkg::NEG_POS] == exec_result[7])
    else $error("negative flag differs from result msb");

  a_zero_result: assert property (
    exec_valid && is_logic |=> flag_q[asf_pkg::ZERO_POS] == (exec_result == 8'h00))
    else $error("zero flag differs from result");

  a_add_carry_out: assert property (
    s_add |=> flag_q[asf_pkg::CARRY_POS] == $past(ref_add[8]))
    else $error("add carry wrong");

  a_add_half_out: assert property (
    s_add |=> flag_q[asf_pkg::HALF_POS] == $past(ref_nib[4]))
    else $error("add half out wrong");

  a_signed_wrap: assert property (
    s_add |=> flag_q[asf_pkg::WRAP_POS] == $past(ref_wrap))
    else $error("signed wrap flag wrong");

  a_sub_not_borrow: assert property (
    s_sub |=> flag_q[asf_pkg::CARRY_POS] == $past(ref_ge)
              && flag_q[asf_pkg::HALF_POS] == $past(ref_nib_ge))
    else $error("subtract borrow polarity wrong");

  a_clear_sets_zero: assert property (
    s_op(asf_pkg::OP_CLR) ##0 flags_loaded
      |=> flag_q[asf_pkg::ZERO_POS] && exec_result == 8'h00
          && $stable(flag_q[asf_pkg::NEG_POS]) && $stable(flag_q[asf_pkg::CARRY_POS]))
    else $error("clear did not leave 000u u1uu");

  a_rotate_left: assert property (
    s_op(asf_pkg::OP_RLC) |=> flag_q[asf_pkg::CARRY_POS] == $past(ref_a[7])
                            && flag_q[asf_pkg::HALF_POS] == $past(ref_a[3]))
    else $error("left rotate carry or half wrong");

  a_rotate_right: assert property (
    s_op(asf_pkg::OP_RRC) |=> flag_q[asf_pkg::CARRY_POS] == $past(ref_a[0])
                            && flag_q[asf_pkg::HALF_POS] == $past(ref_a[4]))
    else $error("right rotate carry or half wrong");

  a_plain_write: assert property (
    s_to_flags ##0 is_plain |=> flag_q == $past(alu_result[4:0]))
    else $error("plain write did not land");

  a_bus_write: assert property (
    sw_wr && !exec_valid |=> flags_view == {3'h0, $past(sw_data)})
    else $error("bus write did not land");

  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[7:5] == 3'h0)
    else $error("unimplemented bits read nonzero");

  a_flags_hold: assert property (
    flags_loaded && !sw_wr && !(exec_valid && (exec_req.dest_flags || affect != 5'h00))
      |=> $stable(flag_q))
    else $error("unaffected flags changed");

  // ****************************************
  // datapath and bus checks
  // ****************************************

  // flags outside the op's set must hold even when the op names the flag register
  a_dest_flags_held: assert property (
    s_to_flags ##0 flags_loaded && affect != 5'h00
      |=> ((flag_q ^ $past(flag_q)) & $past(hold_mask)) == 5'h00)
    else $error("destination data reached a flag the op does not set");

  a_unaffected_hold: assert property (
    exec_valid && flags_loaded && affect != 5'h00
      |=> ((flag_q ^ $past(flag_q)) & $past(hold_mask)) == 5'h00)
    else $error("flag outside the op set changed");

  a_sub_signed_wrap: assert property (
    s_sub |=> flag_q[asf_pkg::WRAP_POS] == $past(ref_sub_wrap))
    else $error("subtract signed wrap flag wrong");

  a_sub_result: assert property (
    s_sub |=> exec_result == $past(ref_diff))
    else $error("subtract result wrong");

  a_add_result: assert property (
    s_add |=> exec_result == $past(ref_add[7:0]))
    else $error("add result wrong");

  a_logic_negative: assert property (
    exec_valid && is_logic |=> flag_q[asf_pkg::NEG_POS] == exec_result[7])
    else $error("negative flag differs from logic result msb");

  a_xor_result: assert property (
    s_op(asf_pkg::OP_XOR) |=> exec_result == $past(exec_req.a ^ exec_req.b))
    else $error("exclusive or result wrong");

  a_rotate_sign_zero: assert property (
    s_rotate |=> flag_q[asf_pkg::NEG_POS] == exec_result[7]
                 && flag_q[asf_pkg::ZERO_POS] == (exec_result == 8'h00))
    else $error("rotate negative or zero flag wrong");

  a_rotate_wrap_held: assert property (
    s_rotate ##0 flags_loaded |=> $stable(flag_q[asf_pkg::WRAP_POS]))
    else $error("rotate changed the signed wrap flag");

  // the old carry is shifted in, so it must be known before the rotate
  a_rotate_left_data: assert property (
    s_op(asf_pkg::OP_RLC) ##0 flags_loaded
      |=> exec_result == {$past(ref_a[6:0]), $past(flag_q[asf_pkg::CARRY_POS])})
    else $error("left rotate did not shift in the old carry");

  a_rotate_right_data: assert property (
    s_op(asf_pkg::OP_RRC) ##0 flags_loaded
      |=> exec_result == {$past(flag_q[asf_pkg::CARRY_POS]), $past(ref_a[7:1])})
    else $error("right rotate did not shift in the old carry");

  a_plain_touches_none: assert property (
    exec_valid && is_plain |-> affect == 5'h00)
    else $error("bit, swap or move op marked a flag as affected");

  a_clear_result: assert property (
    s_op(asf_pkg::OP_CLR) |=> exec_result == 8'h00 && flag_q[asf_pkg::ZERO_POS]
                             && flags_view[7:5] == 3'h0)
    else $error("clear left a nonzero result or zero flag low");

  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read address taken without a read answer");

  // read data is the view registered at the edge the address was taken
  a_read_data: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == asf_pkg::FLAGS_OFFSET
      |=> s_axi_rdata == {24'h00_0000, $past(flags_view)} && s_axi_rresp == asf_pkg::RESP_OKAY)
    else $error("flag register read returned wrong data");

  a_read_refused: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr != asf_pkg::FLAGS_OFFSET
      |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == asf_pkg::RESP_SLVERR)
    else $error("read of an unused address not refused");

  a_write_answer: assert property (
    sw_wr |=> s_axi_bvalid && s_axi_bresp == asf_pkg::RESP_OKAY)
    else $error("flag write not answered with okay");

  a_aw_busy: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready while an address is held");

  a_w_busy: assert property (
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data ready while data is held");

  a_bvalid_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released after bready");

  a_rvalid_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released after rready");

endmodule : alu_status_flags

// ==== asf_pkg.sv ====
// Overview of operation
// - The flag register can be the destination of any instruction like any other data register.
// - When the destination instruction itself affects a flag, the data write to the five flags is dropped.
// - A clear aimed at the flag register zeroes bits 7 to 5 and sets zero, other flags unchanged.
// - Bit clear, bit set, nibble swap and moves touch no flag, so their writes land on all five flag bits.
// - Bits 7 to 5 are unimplemented: writes are ignored and they read back as zero.
// - The negative flag in bit 4 copies the most significant bit of the ALU result.
// - The signed wrap flag in bit 3 is set when a signed operation overflows into the sign bit.
// - The zero flag in bit 2 is set when an arithmetic or logic result is zero, cleared otherwise.
// - For add and subtract the half out flag in bit 1 is the carry out of result bit 3.
// - For add and subtract the carry flag in bit 0 is the carry out of the result MSB.
// - Subtract adds the two's complement of the second operand, so carry and half act as not-borrow.
// - Rotates through carry load the half out flag from source bit 3 (left) or bit 4 (right) by direction.
// - Rotates through carry load the carry flag from the source MSB or LSB by direction.
package asf_pkg;

  localparam int          DATA_W      = 8;
  localparam int          FLAG_W      = 5;
  localparam int          NEG_POS     = 4;
  localparam int          WRAP_POS    = 3;
  localparam int          ZERO_POS    = 2;
  localparam int          HALF_POS    = 1;
  localparam int          CARRY_POS   = 0;
  localparam logic [2:0]  UNIMPL_READ = 3'h0;
  localparam logic [31:0] FLAGS_OFFSET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [7:0]  RESULT_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR,
    OP_MOV, OP_BCLR, OP_BSET, OP_SWAP, OP_RLC, OP_RRC
  } asf_op_t;

  // field order matches bit 4 down to bit 0
  typedef struct packed {
    logic neg;
    logic wrap;
    logic zero;
    logic half;
    logic carry;
  } asf_flags_t;

  // b[2:0] is the bit index for bit clear and bit set
  typedef struct packed {
    asf_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       dest_flags;
  } asf_exec_t;

endpackage : asf_pkg

// ==== asf_alu_core.sv ====
`timescale 1ns/1ps

module asf_alu_core (
  input  asf_pkg::asf_exec_t  req,
  input  wire logic           carry_in,
  output logic [7:0]          result,
  output asf_pkg::asf_flags_t calc,
  output asf_pkg::asf_flags_t affect
);

  logic [7:0] opnd;
  logic       cin;
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb
  begin
    cin  = (req.op == asf_pkg::OP_SUB);
    opnd = cin ? ~req.b : req.b;
    sum  = {1'b0, req.a} + {1'b0, opnd} + {8'h00, cin};
    nib  = {1'b0, req.a[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  end

  always_comb
  begin
    result = req.a;
    calc   = '0;
    affect = '0;
    case (req.op)
      asf_pkg::OP_ADD, asf_pkg::OP_SUB:
      begin
        result = sum[7:0];
        affect = 5'h1F;
        calc.carry = sum[8];
        calc.half = nib[4];
        calc.wrap = (req.a[7] == opnd[7]) && (sum[7] != req.a[7]);
      end
      asf_pkg::OP_AND: begin result = req.a & req.b; affect = 5'h14; end
      asf_pkg::OP_IOR: begin result = req.a | req.b; affect = 5'h14; end
      asf_pkg::OP_XOR: begin result = req.a ^ req.b; affect = 5'h14; end
      asf_pkg::OP_CLR: begin result = 8'h00; affect = 5'h04; end
      asf_pkg::OP_MOV:  result = req.a;
      asf_pkg::OP_BCLR: result = req.a & ~(8'h01 << req.b[2:0]);
      asf_pkg::OP_BSET: result = req.a | (8'h01 << req.b[2:0]);
      asf_pkg::OP_SWAP: result = {req.a[3:0], req.a[7:4]};
      asf_pkg::OP_RLC:
      begin
        result     = {req.a[6:0], carry_in};
        calc.carry = req.a[7];
        calc.half  = req.a[3];
        affect     = 5'h17;
      end
      asf_pkg::OP_RRC:
      begin
        result     = {carry_in, req.a[7:1]};
        calc.carry = req.a[0];
        calc.half  = req.a[4];
        affect     = 5'h17;
      end
      default: result = req.a;
    endcase
    calc.neg = result[7];
    calc.zero = (result == 8'h00);
  end

endmodule : asf_alu_core

// ==== asf_axil_slave.sv ====
`timescale 1ns/1ps

module asf_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [31:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             sw_wr,
  output logic [4:0]       sw_data,
  input  wire logic [7:0]  rd_view
);

  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic        commit;
  logic        aw_hit;
  logic        wstrb_q0;

  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;
  assign commit  = aw_held && w_held && !bvalid;
  assign aw_hit  = (aw_addr == asf_pkg::FLAGS_OFFSET);
  // only the five flag bits are stored
  assign sw_wr   = commit && aw_hit && wstrb_q0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 32'h0000_0000;
      sw_data  <= 5'h00;
      wstrb_q0 <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= asf_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held   <= 1'b1;
        sw_data  <= wdata[4:0];
        wstrb_q0 <= wstrb[0];
      end
      if (commit)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= aw_hit ? asf_pkg::RESP_OKAY : asf_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= asf_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= (araddr == asf_pkg::FLAGS_OFFSET) ? {24'h00_0000, rd_view} : 32'h0000_0000;
      rresp  <= (araddr == asf_pkg::FLAGS_OFFSET) ? asf_pkg::RESP_OKAY : asf_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

endmodule : asf_axil_slave

// ==== asf_exec_model.sv ====
`timescale 1ns/1ps

// ****************************************
// instruction issue side of the flag block
// ****************************************
module asf_exec_model (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          cmd_valid,
  input  asf_pkg::asf_exec_t cmd,
  output logic               exec_valid,
  output asf_pkg::asf_exec_t exec_req
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      exec_valid <= 1'b0;
    else
      exec_valid <= cmd_valid;
  end

  // idle cycles scramble the request, so a stale op is never mistaken for a live one
  always_ff @(posedge aclk)
  begin
    if (cmd_valid)
      exec_req <= cmd;
    else
      exec_req <= asf_pkg::asf_exec_t'(~exec_req);
  end
endmodule : asf_exec_model

// ==== tb_alu_status_flags.sv ====
`timescale 1ns/1ps

module tb_alu_status_flags;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic               cmd_valid = 1'b0;
  asf_pkg::asf_exec_t cmd = '0;
  logic               exec_valid;
  asf_pkg::asf_exec_t exec_req;
  logic [7:0]         exec_result;
  logic [7:0]         flags_view;
  logic               awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic               arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [31:0]        awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0]         wstrb = 4'h0;
  logic [1:0]         bresp, rresp, resp;
  logic [31:0]        rd;
  int                 bad_count = 0;
  int                 checks_done = 0;
  int                 i;
  asf_pkg::asf_op_t   ops [8] = '{asf_pkg::OP_ADD, asf_pkg::OP_ADD, asf_pkg::OP_ADD, asf_pkg::OP_ADD,
                                  asf_pkg::OP_SUB, asf_pkg::OP_SUB, asf_pkg::OP_SUB, asf_pkg::OP_SUB};
  logic [7:0]         va [8] = '{8'h7F, 8'hFF, 8'h0F, 8'h80, 8'h05, 8'h00, 8'h80, 8'h10};
  logic [7:0]         vb [8] = '{8'h01, 8'h01, 8'h01, 8'h80, 8'h05, 8'h01, 8'h01, 8'h01};

  always #5 aclk = ~aclk;

  asf_exec_model u_model (.aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid), .cmd(cmd),
                          .exec_valid(exec_valid), .exec_req(exec_req));

  alu_status_flags DUT (.aclk(aclk), .aresetn(aresetn), .exec_valid(exec_valid), .exec_req(exec_req),
    .exec_result(exec_result), .flags_view(flags_view), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // ready is sampled at the falling edge; inputs only move after rising edges, so it equals the edge value
  task automatic axi_wr(input logic [31:0] ad, input logic [31:0] d, input logic [3:0] st);
    logic a_d, w_d, b_d, ha, hw, hb;
    int   n;
    a_d = 0; w_d = 0; b_d = 0; n = 0;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= ad; wvalid <= 1'b1; wdata <= d; wstrb <= st; bready <= 1'b1;
    while (!b_d && n < 50)
    begin
      @(negedge aclk);
      ha = !a_d && awready; hw = !w_d && wready; hb = bvalid;
      if (hb) resp = bresp;
      @(posedge aclk);
      if (ha) begin awvalid <= 1'b0; a_d = 1; end
      if (hw) begin wvalid <= 1'b0; w_d = 1; end
      if (hb) begin bready <= 1'b0; b_d = 1; end
      n++;
    end
    if (!b_d) begin bad_count++; final_report(); end
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] ad);
    logic a_d, r_d, ha, hr;
    int   n;
    a_d = 0; r_d = 0; n = 0;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= ad; rready <= 1'b1;
    while (!r_d && n < 50)
    begin
      @(negedge aclk);
      ha = !a_d && arready; hr = rvalid;
      if (hr) begin rd = rdata; resp = rresp; end
      @(posedge aclk);
      if (ha) begin arvalid <= 1'b0; a_d = 1; end
      if (hr) begin rready <= 1'b0; r_d = 1; end
      n++;
    end
    if (!r_d) begin bad_count++; final_report(); end
  endtask : axi_rd

  // one op through the model, then let the registered answer settle
  task automatic ex(input asf_pkg::asf_op_t op, input logic [7:0] a, input logic [7:0] b, input logic d,
                    input logic [7:0] er, input logic [4:0] ef);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, a: a, b: b, dest_flags: d};
    @(posedge aclk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    chk("exec_result", {24'h0, exec_result}, {24'h0, er});
    chk("flags_view", {24'h0, flags_view}, {27'h0, ef});
  endtask : ex

  function automatic logic [12:0] arith(input logic [7:0] a, input logic [7:0] b, input logic sub);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h0, sub};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    return {s[7:0], s[7], (a[7] == bb[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction : arith

  initial
  begin
    logic [12:0] e;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(32'h0, 32'hFF, 4'hF); chk("bresp", {30'h0, resp}, {30'h0, asf_pkg::RESP_OKAY});
    axi_rd(32'h0); chk("rdata", rd, 32'h1F);
    axi_wr(32'h0, 32'h00, 4'h0); axi_rd(32'h0); chk("rdata strb0", rd, 32'h1F);
    axi_wr(32'h4, 32'h00, 4'hF); chk("bresp bad", {30'h0, resp}, {30'h0, asf_pkg::RESP_SLVERR});
    axi_rd(32'h4); chk("rresp bad", {30'h0, resp}, {30'h0, asf_pkg::RESP_SLVERR});
    chk("rdata bad", rd, 32'h0);
    $display("test bus access done");
    for (i = 0; i < 8; i++)
    begin
      e = arith(va[i], vb[i], ops[i] == asf_pkg::OP_SUB);
      ex(ops[i], va[i], vb[i], 1'b0, e[12:5], e[4:0]);
    end
    $display("test add and subtract done");
    axi_wr(32'h0, 32'h0B, 4'h1);
    ex(asf_pkg::OP_AND, 8'hF0, 8'h0F, 1'b0, 8'h00, 5'h0F);
    ex(asf_pkg::OP_IOR, 8'hF0, 8'h0F, 1'b0, 8'hFF, 5'h1B);
    ex(asf_pkg::OP_XOR, 8'hF0, 8'h0F, 1'b0, 8'hFF, 5'h1B);
    $display("test logic ops done");
    axi_wr(32'h0, 32'h13, 4'h1);
    ex(asf_pkg::OP_CLR, 8'h5A, 8'h00, 1'b1, 8'h00, 5'h17);
    ex(asf_pkg::OP_ADD, 8'h7F, 8'h01, 1'b1, 8'h80, 5'h1A);
    $display("test flag destination done");
    axi_wr(32'h0, 32'h00, 4'h1);
    ex(asf_pkg::OP_MOV, 8'hEA, 8'hEA, 1'b1, 8'hEA, 5'h0A);
    ex(asf_pkg::OP_BCLR, 8'hEA, 8'h03, 1'b1, 8'hE2, 5'h02);
    ex(asf_pkg::OP_BSET, 8'hEA, 8'h04, 1'b1, 8'hFA, 5'h1A);
    ex(asf_pkg::OP_SWAP, 8'hEA, 8'h00, 1'b1, 8'hAE, 5'h0E);
    $display("test untouched flags done");
    axi_wr(32'h0, 32'h09, 4'h1);
    ex(asf_pkg::OP_RLC, 8'h88, 8'h00, 1'b0, 8'h11, 5'h0B);
    ex(asf_pkg::OP_RRC, 8'h11, 8'h00, 1'b0, 8'h88, 5'h1B);
    ex(asf_pkg::OP_RRC, 8'h00, 8'h00, 1'b0, 8'h80, 5'h18);
    $display("test rotates done");
    final_report();
  end
endmodule : tb_alu_status_flags
